// ### core/ilo_exec.v
// indexed literal offset execution unit: add, bit set and fill forms
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ilo_decode_map.vh"
module ilo_exec (
  // clock and reset
  input wire clk,
  input wire rst,
  // configuration and core state
  input wire extensionEnableCfgBit,
  input wire [11:0] indirectPointerTwo,
  input wire [3:0] bankSelectRegister,
  // instruction issue, one per instruction cycle
  input wire instrValid,
  input wire [15:0] instrWord,
  // data memory read port, combinational from memAddr
  output wire [11:0] memAddr,
  input wire [7:0] memReadData,
  // registered results
  output reg memWrite,
  output reg [11:0] memWriteAddr,
  output reg [7:0] memWriteData,
  output reg [7:0] accumulator,
  output reg [4:0] statusFlags,
  output reg done,
  output reg illegal
);
  //--------------------------------------------------
  // decode
  //--------------------------------------------------
  wire [11:0] effAddr;
  wire indexed;
  wire isAdd = instrWord[15:10] == `ILO_OP_ADD_HI;
  wire isBsf = instrWord[15:12] == `ILO_OP_BSF_HI;
  wire isSetf = instrWord[15:8] == `ILO_OP_FILL_ONES_INDEXED_HI;
  wire destReg = instrWord[`ILO_DEST_BIT];
  wire [2:0] bitSel = instrWord[`ILO_BIT_LSB+2:`ILO_BIT_LSB];

  // shared resolver; a is bit 8, forced to 0 by the encoding only in the fill form
  ilo_addr_resolve uResolve (
    .addrField(instrWord[7:0]),
    .accessBankSel(instrWord[`ILO_ABANK_BIT]),
    .extensionEnable(extensionEnableCfgBit),
    .indirectPointerTwo(indirectPointerTwo),
    .bankSelectRegister(bankSelectRegister),
    .effAddr(effAddr),
    .indexed(indexed)
  );
  assign memAddr = effAddr;

  //--------------------------------------------------
  // datapath
  //--------------------------------------------------
  wire [8:0] sum = {1'b0, accumulator} + {1'b0, memReadData};
  wire [4:0] lowSum = {1'b0, accumulator[3:0]} + {1'b0, memReadData[3:0]};
  wire [7:0] sumByte = sum[7:0];
  wire ovf = (accumulator[7] == memReadData[7]) && (sumByte[7] != accumulator[7]);
  wire known = indexed && (isAdd || isBsf || isSetf);

  // one instruction per cycle; pointer is never written here
  always @(posedge clk) begin
    if (rst) begin
      memWrite <= 1'b0;
      memWriteAddr <= 12'h000;
      memWriteData <= `ILO_ZERO8;
      accumulator <= `ILO_ZERO8;
      statusFlags <= 5'h00;
      done <= 1'b0;
      illegal <= 1'b0;
    end else begin
      memWrite <= 1'b0;
      done <= 1'b0;
      illegal <= 1'b0;
      if (instrValid) begin
        done <= known;
        illegal <= !known; // only indexed forms are handled by this unit
        memWriteAddr <= effAddr;
        if (known && isAdd) begin
          statusFlags[`ILO_FLAG_C] <= sum[8];
          statusFlags[`ILO_FLAG_DC] <= lowSum[4];
          statusFlags[`ILO_FLAG_Z] <= sumByte == `ILO_ZERO8;
          statusFlags[`ILO_FLAG_OV] <= ovf;
          statusFlags[`ILO_FLAG_N] <= sumByte[7];
          if (destReg) begin
            memWrite <= 1'b1;
            memWriteData <= sumByte;
          end else begin
            accumulator <= sumByte;
          end
        end else if (known && isBsf) begin
          memWrite <= 1'b1;
          memWriteData <= memReadData | (8'h01 << bitSel);
        end else if (known && isSetf) begin
          memWrite <= 1'b1;
          memWriteData <= `ILO_ALL_ONES;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### core/ilo_decode_map.vh
// constants for the indexed literal offset decoder
`ifndef ILO_DECODE_MAP_VH
`define ILO_DECODE_MAP_VH
`define ILO_OFFSET_MAX 8'h005F
`define ILO_OP_ADD_HI 6'h09
`define ILO_OP_BSF_HI 4'h8
`define ILO_OP_FILL_ONES_INDEXED_HI 8'h68
`define ILO_DEST_BIT 9
`define ILO_ABANK_BIT 8
`define ILO_BIT_LSB 9
`define ILO_ALL_ONES 8'hFF
`define ILO_FLAG_C 0
`define ILO_FLAG_DC 1
`define ILO_FLAG_Z 2
`define ILO_FLAG_OV 3
`define ILO_FLAG_N 4
`define ILO_ACC_HI 8'h80
`define ILO_SFR_PAGE 4'hF
`define ILO_ZERO8 8'h00
`endif

// ### core/ilo_addr_resolve.v
// effective data address resolution for access bank and indexed operands
`timescale 1ns/1ps
`default_nettype none
`include "ilo_decode_map.vh"
module ilo_addr_resolve (
  // operand
  input wire [7:0] addrField,
  input wire accessBankSel,
  // mode and pointers
  input wire extensionEnable,
  input wire [11:0] indirectPointerTwo,
  input wire [3:0] bankSelectRegister,
  // result
  output reg [11:0] effAddr,
  output reg indexed
);
  // pointer-relative only for a=0 and field within the offset window
  always @* begin
    indexed = extensionEnable && !accessBankSel && (addrField <= `ILO_OFFSET_MAX);
    if (indexed) begin
      // full pointer plus zero-extended offset; pointer 0 lands on legacy locations
      effAddr = indirectPointerTwo + {4'h0, addrField};
    end else if (accessBankSel) begin
      effAddr = {bankSelectRegister, addrField};
    end else if (addrField < `ILO_ACC_HI) begin
      effAddr = {4'h0, addrField};
    end else begin
      effAddr = {`ILO_SFR_PAGE, addrField};
    end
  end
endmodule
`default_nettype wire

// ### dv/ilo_exec_asserts.sv
// checker for the indexed execution unit
`timescale 1ns/1ps
`default_nettype none
module ilo_exec_asserts (
  // watched ports
  input wire clk, rst, extensionEnableCfgBit, instrValid, memWrite, done, illegal,
  input wire [3:0] bankSelectRegister,
  input wire [4:0] statusFlags,
  input wire [7:0] memReadData, memWriteData, accumulator,
  input wire [11:0] indirectPointerTwo, memAddr,
  input wire [15:0] instrWord
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // legal indexed forms only: a=0 and offset up to 5Fh
  wire idx = instrValid && extensionEnableCfgBit && !instrWord[8] && instrWord[7:0] < 8'h60
    && (instrWord[15:10] == 6'h09 || instrWord[15:12] == 4'h8 || instrWord[15:8] == 8'h68);
  wire addW = idx && instrWord[15:10] == 6'h09 && !instrWord[9];
  idx_done_a: assert property (idx |=> done) else $error("done");
  refuse_op_a: assert property (instrValid && !idx |=> illegal && !memWrite) else $error("ill");
  ptr_addr_a: assert property (
    idx |-> memAddr == indirectPointerTwo + instrWord[7:0]) else $error("addr");
  bank_addr_a: assert property (
    instrValid && instrWord[8] |-> memAddr == {bankSelectRegister, instrWord[7:0]}) else $error("bank");
  fill_ones_a: assert property (
    idx && instrWord[15:8] == 8'h68 |=> memWriteData == 8'hFF && $stable(statusFlags)) else $error("fill");
  carry_flag_a: assert property (
    idx && instrWord[15:10] == 6'h09 |=> statusFlags[0] ==
    (({1'b0, $past(accumulator)} + {1'b0, $past(memReadData)}) > 9'h0FF)) else $error("carry");
  bit_set_a: assert property (
    idx && instrWord[15] |=> memWriteData == ($past(memReadData) | 8'h01 << $past(instrWord[11:9]))
    && $stable(statusFlags)) else $error("bset");
  acc_sum_a: assert property (
    addW |=> accumulator == $past(accumulator) + $past(memReadData) && !memWrite) else $error("acc");
  zero_flag_a: assert property (
    addW |=> statusFlags[2] == (accumulator == 8'h00)) else $error("zero");
endmodule
bind ilo_exec ilo_exec_asserts u_chk (.*);
`default_nettype wire

// ### dv/test_indexed_literal_offset_decode.sv
// random bench for the indexed execution unit
`timescale 1ns/1ps
`default_nettype none
module test_indexed_literal_offset_decode;
  reg clk = 0, rst = 1, en = 1, vld = 0, idx, wr;
  reg [3:0] bank_select_register = 0;
  reg [7:0] salt = 0, acc = 0, m, r, k, b;
  reg [4:0] fe = 0;
  reg [11:0] ptr = 0, ea;
  reg [15:0] iw = 0, w;
  wire [11:0] ma, wa;
  wire [7:0] wd, accO;
  wire [4:0] fl;
  wire mw, dn, il;
  integer seed = 48138, n_errors = 0, cmp_count = 0, i;
  always #10 clk = ~clk;
  // read data follows the low address byte so a wrong low byte shows as wrong data
  ilo_exec u_dut (.clk(clk), .rst(rst), .extensionEnableCfgBit(en), .indirectPointerTwo(ptr),
    .bankSelectRegister(bank_select_register), .instrValid(vld), .instrWord(iw), .memAddr(ma),
    .memReadData(ma[7:0] ^ salt), .memWrite(mw), .memWriteAddr(wa), .memWriteData(wd),
    .accumulator(accO), .statusFlags(fl), .done(dn), .illegal(il));
  task chk(input [31:0] nm, input [11:0] s, e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        n_errors = n_errors + 1;
        $display("BAD %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  // expected flags of an add, packed N OV Z DC C from bit 4 down
  function [4:0] add_flags(input [7:0] a, input [7:0] v);
    reg [8:0] s;
    begin
      s = a + v;
      add_flags = {s[7], (a[7] == v[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
        (a[3:0] + v[3:0]) > 5'h0f, s[8]};
    end
  endfunction
  task stop_test;
    begin
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    #100000 n_errors = n_errors + 1;
    stop_test;
  end
  // offsets 5Fh/60h and a zero pointer first, then random; extension off at the end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    for (i = 0; i < 150; i = i + 1) begin
      k = (i < 2) ? 8'h5F + i : $random(seed);
      b = $random(seed);
      w = (i % 3 == 0) ? {6'h09, b[0], b[1] & (i > 120), k} : (i % 3 == 1) ? {4'h8, b[2:0], 1'b0, k} : {8'h68, k};
      @(posedge clk);
      iw <= w;
      vld <= 1;
      en <= (i < 120);
      ptr <= (i < 6) ? 12'h000 : $random(seed);
      salt <= $random(seed);
      bank_select_register <= $random(seed);
      #1 idx = en && !w[8] && k < 8'h60;
      ea = w[8] ? {bank_select_register, k} : idx ? ptr + k : {{4{k[7]}}, k};
      m = ea[7:0] ^ salt;
      r = (i % 3 == 0) ? acc + m : (i % 3 == 1) ? m | 8'h01 << b[2:0] : 8'hFF;
      wr = idx && !(i % 3 == 0 && !w[9]);
      if (idx && i % 3 == 0) fe = add_flags(acc, m);
      chk("addr", ma, ea);
      @(posedge clk);
      vld <= 0;
      #1 chk("done", dn, idx);
      chk("wr", mw, wr);
      if (idx && !wr) acc = r;
      chk("acc", accO, acc);
      chk("flags", fl, fe);
      if (wr) chk("data", wd, r);
      if (wr) chk("wadr", wa, ea);
    end
    stop_test;
  end
endmodule
`default_nettype wire
